// *** ssp_cmd.sv ***
// Command interpreter for the sanitize status query and lock removal.
// Assumes the host adapter presents a loaded command block with a one-cycle
// command strobe and streams data words with a valid strobe while DRQ is set.
`timescale 1ns/10ps
`default_nettype none
module ssp_cmd #(
    parameter int PW_WORDS = 16
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic cmd_valid,
    input wire logic [7:0] cmd_opcode,
    input wire logic [15:0] cmd_feature,
    input wire logic [15:0] cmd_count,
    input wire logic data_valid,
    input wire logic [15:0] data_word,
    input wire logic san_start,
    input wire logic san_fail_hold,
    input wire logic san_done_ok,
    input wire logic san_done_fail,
    input wire logic san_freeze,
    input wire logic [15:0] san_progress,
    input wire logic success_keep,
    input wire logic security_enabled,
    input wire logic [PW_WORDS*16-1:0] user_password,
    input wire logic [PW_WORDS*16-1:0] master_password,
    output logic [7:0] command_error_flags,
    output logic [7:0] command_status_flags,
    output logic [15:0] result_count,
    output logic [7:0] result_sector_number,
    output logic [7:0] result_cylinder_low,
    output logic lock_disable,
    output logic success_store
);
    typedef enum logic [2:0] {
        SSP_IDLE = 3'b001,
        SSP_XFER = 3'b010,
        SSP_CHECK = 3'b100
    } ssp_cmd_e;

    ssp_cmd_e cmd_reg;
    ssp_pkg::ssp_san_e san_state;
    logic fail_hold_option;
    logic clear_fail;
    logic pw_start;
    logic pw_done;
    logic pw_match;
    logic pw_master;
    logic success_reg;
    logic is_status;
    logic is_unlock;
    logic clear_req;

    // Command decode
    assign is_status = cmd_valid && cmd_opcode == ssp_pkg::CMD_SANITIZE
                       && cmd_feature == ssp_pkg::FEAT_STATUS;
    assign is_unlock = cmd_valid && cmd_opcode == ssp_pkg::CMD_UNLOCK && cmd_reg == SSP_IDLE;
    assign clear_req = cmd_count[ssp_pkg::CLR_FAIL_BIT];
    assign clear_fail = is_status && clear_req && san_state == ssp_pkg::SANITIZE_FAILED_STATE;
    assign pw_start = is_unlock;

    ssp_san_fsm u_san (
        .clk(clk),
        .rst_b(rst_b),
        .san_start(san_start),
        .san_fail_hold(san_fail_hold),
        .san_done_ok(san_done_ok),
        .san_done_fail(san_done_fail),
        .san_freeze(san_freeze),
        .clear_fail(clear_fail),
        .state(san_state),
        .fail_hold_option(fail_hold_option)
    );

    ssp_pw_cmp #(
        .PW_WORDS(PW_WORDS)
    ) u_pw (
        .clk(clk),
        .rst_b(rst_b),
        .start(pw_start),
        .word_valid(data_valid && cmd_reg == SSP_XFER),
        .word_data(data_word),
        .user_pw(user_password),
        .master_pw(master_password),
        .sector_done(pw_done),
        .match(pw_match),
        .select_master(pw_master)
    );

    // Success bit lives outside this block in retained storage; it is
    // reloaded from success_keep after reset and mirrored back out.
    logic seeded_reg;
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            success_reg <= 1'b0;
            seeded_reg <= 1'b0;
        end else if (!seeded_reg) begin
            success_reg <= success_keep;
            seeded_reg <= 1'b1;
        end else if (san_state == ssp_pkg::SANITIZE_SUCCEEDED_STATE) begin
            success_reg <= 1'b1;
        end else if (san_state == ssp_pkg::SANITIZE_OPERATING_STATE) begin
            success_reg <= 1'b0;
        end
    end
    assign success_store = success_reg;

    // Command sequencer for lock removal; the query finishes in one cycle
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cmd_reg <= SSP_IDLE;
        end else begin
            unique case (cmd_reg)
                SSP_IDLE: begin
                    // Every accepted unlock takes its sector first; refusal is judged at check
                    if (is_unlock) begin
                        cmd_reg <= SSP_XFER;
                    end
                end
                SSP_XFER: begin
                    if (pw_done) cmd_reg <= SSP_CHECK;
                end
                SSP_CHECK: begin
                    cmd_reg <= SSP_IDLE;
                end
                default: cmd_reg <= SSP_IDLE;
            endcase
        end
    end

    // Lock disable pulse; passwords are inputs only, so master stays intact
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            lock_disable <= 1'b0;
        end else begin
            lock_disable <= cmd_reg == SSP_CHECK && pw_match && security_enabled;
        end
    end

    // Result registers for the status query; every state answers
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            result_count <= 16'h0000;
            result_sector_number <= ssp_pkg::PROGRESS_IDLE[7:0];
            result_cylinder_low <= ssp_pkg::PROGRESS_IDLE[15:8];
        end else if (is_status) begin
            result_count <= 16'h0000;
            result_count[ssp_pkg::CNT_SUCCESS_BIT] <= success_reg;
            result_count[ssp_pkg::CNT_BUSY_BIT] <= san_state == ssp_pkg::SANITIZE_OPERATING_STATE;
            result_count[ssp_pkg::CNT_FROZEN_BIT] <= san_state == ssp_pkg::SANITIZE_FROZEN_STATE;
            if (san_state == ssp_pkg::SANITIZE_OPERATING_STATE) begin
                result_cylinder_low <= san_progress[15:8];
                result_sector_number <= san_progress[7:0];
            end else begin
                result_cylinder_low <= ssp_pkg::PROGRESS_IDLE[15:8];
                result_sector_number <= ssp_pkg::PROGRESS_IDLE[7:0];
            end
            if (clear_req && !fail_hold_option) begin
                result_sector_number <= ssp_pkg::REASON_NONE;
            end else if (san_state == ssp_pkg::SANITIZE_FAILED_STATE && !clear_req) begin
                result_sector_number <= ssp_pkg::REASON_UNSANITIZED;
            end
        end else if (cmd_valid && cmd_opcode == ssp_pkg::CMD_SANITIZE) begin
            // Unsupported feature values report why they failed
            result_sector_number <= (san_state == ssp_pkg::SANITIZE_FROZEN_STATE)
                                    ? ssp_pkg::REASON_FROZEN : ssp_pkg::REASON_BAD_FEATURE;
        end
    end

    // Error and status flags; abort when required, DRQ during transfer, busy while checking after it
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            command_error_flags <= ssp_pkg::ERR_RESET;
            command_status_flags <= ssp_pkg::STS_RESET;
        end else if (is_status) begin
            if ((clear_req && !fail_hold_option)
                || (san_state == ssp_pkg::SANITIZE_FAILED_STATE && !(clear_req && fail_hold_option))) begin
                command_error_flags <= 8'h04;
                command_status_flags <= 8'h51;
            end else begin
                command_error_flags <= ssp_pkg::ERR_RESET;
                command_status_flags <= ssp_pkg::STS_RESET;
            end
        end else if (cmd_valid && cmd_opcode == ssp_pkg::CMD_SANITIZE) begin
            command_error_flags <= 8'h04;
            command_status_flags <= 8'h51;
        end else if (is_unlock) begin
            command_error_flags <= ssp_pkg::ERR_RESET;
            command_status_flags <= 8'h58; // DRQ asks the host for the sector
        end else if (cmd_reg == SSP_CHECK) begin
            // Disabled with user selection, or mismatch, aborts
            if ((!security_enabled && !pw_master) || !pw_match) begin
                command_error_flags <= 8'h04;
                command_status_flags <= 8'h51;
            end else begin
                command_error_flags <= ssp_pkg::ERR_RESET;
                command_status_flags <= ssp_pkg::STS_RESET;
            end
        end else if (cmd_reg == SSP_XFER && pw_done) begin
            command_status_flags <= 8'hd0; // Busy while checking
        end
    end
endmodule : ssp_cmd
`default_nettype wire

// *** ssp_pkg.sv ***
// Package for the sanitize status and password unlock command block.
// Assumes a single 10 MHz clock domain; no other package is used.
package ssp_pkg;
    // Command opcodes and feature selector
    localparam logic [7:0] CMD_SANITIZE = 8'hb4;
    localparam logic [7:0] CMD_UNLOCK = 8'hf6;
    localparam logic [15:0] FEAT_STATUS = 16'h0000;
    // Count field bit positions
    localparam int CLR_FAIL_BIT = 0;
    localparam int CNT_SUCCESS_BIT = 15;
    localparam int CNT_BUSY_BIT = 14;
    localparam int CNT_FROZEN_BIT = 13;
    // Error and status register bit positions
    localparam int ERR_ABORT_BIT = 2;
    localparam int STS_BSY_BIT = 7;
    localparam int STS_RDY_BIT = 6;
    localparam int STS_DSC_BIT = 4;
    localparam int STS_DRQ_BIT = 3;
    localparam int STS_ERR_BIT = 0;
    // Reset values
    localparam logic [7:0] ERR_RESET = 8'h00;
    localparam logic [7:0] STS_RESET = 8'h50;
    localparam logic [15:0] PROGRESS_IDLE = 16'hffff;
    // Sanitize reason codes
    localparam logic [7:0] REASON_NONE = 8'h00;
    localparam logic [7:0] REASON_UNSANITIZED = 8'h01;
    localparam logic [7:0] REASON_BAD_FEATURE = 8'h02;
    localparam logic [7:0] REASON_FROZEN = 8'h03;
    // Password sector layout in 16-bit words
    localparam int SECTOR_WORDS = 256;
    localparam int PW_FIRST_WORD = 1;
    localparam int PW_LAST_WORD = 16;
    localparam int SELECT_BIT = 0;
    // Sanitize states
    typedef enum logic [4:0] {
        SANITIZE_IDLE_STATE = 5'b00001,
        SANITIZE_FROZEN_STATE = 5'b00010,
        SANITIZE_OPERATING_STATE = 5'b00100,
        SANITIZE_FAILED_STATE = 5'b01000,
        SANITIZE_SUCCEEDED_STATE = 5'b10000
    } ssp_san_e;
endpackage : ssp_pkg

// *** ssp_san_fsm.sv ***
// Sanitize device state machine for the status query path.
// Assumes start, done, freeze and clear events are one-cycle pulses on clk.
`timescale 1ns/10ps
`default_nettype none
module ssp_san_fsm (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic san_start,
    input wire logic san_fail_hold,
    input wire logic san_done_ok,
    input wire logic san_done_fail,
    input wire logic san_freeze,
    input wire logic clear_fail,
    output var ssp_pkg::ssp_san_e state,
    output logic fail_hold_option
);
    ssp_pkg::ssp_san_e state_reg;
    assign state = state_reg;

    // State transitions; reset always lands in idle, which leaves frozen
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_reg <= ssp_pkg::SANITIZE_IDLE_STATE;
        end else begin
            unique case (state_reg)
                ssp_pkg::SANITIZE_IDLE_STATE,
                ssp_pkg::SANITIZE_SUCCEEDED_STATE: begin
                    if (san_freeze) state_reg <= ssp_pkg::SANITIZE_FROZEN_STATE;
                    else if (san_start) state_reg <= ssp_pkg::SANITIZE_OPERATING_STATE;
                end
                ssp_pkg::SANITIZE_FROZEN_STATE: begin
                    state_reg <= ssp_pkg::SANITIZE_FROZEN_STATE;
                end
                ssp_pkg::SANITIZE_OPERATING_STATE: begin
                    if (san_done_fail) state_reg <= ssp_pkg::SANITIZE_FAILED_STATE;
                    else if (san_done_ok) state_reg <= ssp_pkg::SANITIZE_SUCCEEDED_STATE;
                end
                ssp_pkg::SANITIZE_FAILED_STATE: begin
                    if (clear_fail && fail_hold_option) state_reg <= ssp_pkg::SANITIZE_IDLE_STATE;
                    else if (san_start) state_reg <= ssp_pkg::SANITIZE_OPERATING_STATE;
                end
                default: state_reg <= ssp_pkg::SANITIZE_IDLE_STATE;
            endcase
        end
    end

    // Option captured from any start in failed, even one a clear overrides; a freeze
    // in the same cycle wins in idle or succeeded, so the option stays put
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            fail_hold_option <= 1'b0;
        end else if (san_start && (state_reg == ssp_pkg::SANITIZE_FAILED_STATE
                     || ((state_reg == ssp_pkg::SANITIZE_IDLE_STATE
                     || state_reg == ssp_pkg::SANITIZE_SUCCEEDED_STATE) && !san_freeze))) begin
            fail_hold_option <= san_fail_hold;
        end
    end
endmodule : ssp_san_fsm
`default_nettype wire

// *** ssp_pw_cmp.sv ***
// Streaming comparator for the 512-byte password sector.
// Assumes words arrive in order, word 0 first, one per valid cycle.
`timescale 1ns/10ps
`default_nettype none
module ssp_pw_cmp #(
    parameter int PW_WORDS = 16
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic start,
    input wire logic word_valid,
    input wire logic [15:0] word_data,
    input wire logic [PW_WORDS*16-1:0] user_pw,
    input wire logic [PW_WORDS*16-1:0] master_pw,
    output logic sector_done,
    output logic match,
    output logic select_master
);
    logic [8:0] index_reg;
    logic match_reg;

    // Password word picked by index; only words 1..16 are compared
    function automatic logic [15:0] pw_word(input logic [PW_WORDS*16-1:0] pw, input logic [8:0] idx);
        pw_word = pw[(idx - 9'd1) * 16 +: 16];
    endfunction : pw_word

    assign match = match_reg;

    // Word counter; a new command restarts it
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            index_reg <= 9'h000;
            sector_done <= 1'b0;
        end else begin
            sector_done <= 1'b0;
            if (start) begin
                index_reg <= 9'h000;
            end else if (word_valid) begin
                index_reg <= index_reg + 9'd1;
                sector_done <= (index_reg == 9'(ssp_pkg::SECTOR_WORDS - 1));
            end
        end
    end

    // Selector and running match; reserved words and bits are ignored
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            select_master <= 1'b0;
            match_reg <= 1'b0;
        end else if (start) begin
            match_reg <= 1'b1;
        end else if (word_valid) begin
            if (index_reg == 9'h000) begin
                select_master <= word_data[ssp_pkg::SELECT_BIT];
            end else if (index_reg >= 9'(ssp_pkg::PW_FIRST_WORD) && index_reg <= 9'(ssp_pkg::PW_LAST_WORD)) begin
                if (word_data != (select_master ? pw_word(master_pw, index_reg) : pw_word(user_pw, index_reg))) begin
                    match_reg <= 1'b0;
                end
            end
        end
    end
endmodule : ssp_pw_cmp
`default_nettype wire

// *** ssp_host_model.sv ***
// Host adapter model: loads the command block and streams the data sector.
// Drives on the falling edge of clk; the block samples on the rising edge.
`timescale 1ns/10ps
`default_nettype none
module ssp_host_model (
    input wire logic clk,
    output logic cmd_valid,
    output logic [7:0] cmd_opcode,
    output logic [15:0] cmd_feature,
    output logic [15:0] cmd_count,
    output logic data_valid,
    output logic [15:0] data_word
);
    // Quiet bus at time zero
    initial begin
        cmd_valid = 1'b0;
        cmd_opcode = 8'h00;
        cmd_feature = 16'h0000;
        cmd_count = 16'h0000;
        data_valid = 1'b0;
        data_word = 16'h0000;
    end

    // One-cycle strobe; the loaded block stays until the next command
    task automatic issue(input logic [7:0] op, input logic [15:0] feat, input logic [15:0] cnt);
        @(negedge clk);
        cmd_opcode = op;
        cmd_feature = feat;
        cmd_count = cnt;
        cmd_valid = 1'b1;
        @(negedge clk);
        cmd_valid = 1'b0;
    endtask : issue

    // Whole sector back to back; reserved words carry junk so they must be ignored
    task automatic sector(input logic sel, input logic [255:0] pw);
        for (int i = 0; i < 256; i++) begin
            data_word = i == 0 ? {15'h0000, sel} : (i <= 16 ? pw[(i-1)*16 +: 16] : 16'(i) ^ 16'ha5a5);
            data_valid = 1'b1;
            @(negedge clk);
        end
        data_valid = 1'b0;
        // Released line flips so a stale word cannot pass for a fresh one
        data_word = ~data_word;
    endtask : sector
endmodule : ssp_host_model
`default_nettype wire

// *** ssp_cmd_monitor.sv ***
// Checker for the command block: results, flags and the lock pulse.
// Sees only the ports of ssp_cmd; bound from the testbench top.
`timescale 1ns/10ps
`default_nettype none
module ssp_cmd_monitor #(
    parameter int PW_WORDS = 16
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic cmd_valid,
    input wire logic [7:0] cmd_opcode,
    input wire logic [15:0] cmd_feature,
    input wire logic [15:0] san_progress,
    input wire logic [7:0] command_error_flags,
    input wire logic [7:0] command_status_flags,
    input wire logic [15:0] result_count,
    input wire logic [7:0] result_sector_number,
    input wire logic [7:0] result_cylinder_low,
    input wire logic lock_disable,
    input wire logic success_store
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    // Query taken; results are judged two edges on so either answer phase is covered
    logic qry;
    logic ok;
    assign qry = cmd_valid && cmd_opcode == ssp_pkg::CMD_SANITIZE;
    assign ok = !command_error_flags[2];

    a_query_answer: assert property (qry |=> ##1 !command_status_flags[7])
        else $error("query left the block busy");
    a_idle_progress: assert property ($past(qry && cmd_feature == 16'h0000, 2) && ok && !result_count[14]
        |-> {result_cylinder_low, result_sector_number} == 16'hffff) else $error("idle progress not ffff");
    a_progress_bytes: assert property ($past(qry && cmd_feature == 16'h0000, 2) && ok && result_count[14]
        |-> {result_cylinder_low, result_sector_number} == $past(san_progress, 2)) else $error("progress bytes wrong");
    a_bad_feature: assert property (qry && cmd_feature != 16'h0000
        |-> ##2 !ok && result_sector_number inside {8'h02, 8'h03}) else $error("bad feature not refused");
    a_abort_flags: assert property ($rose(command_error_flags[2]) |-> command_status_flags == 8'h51)
        else $error("abort status wrong");
    a_unlock_drq: assert property (cmd_valid && cmd_opcode == ssp_pkg::CMD_UNLOCK && !command_status_flags[7]
        && !command_status_flags[3] |-> ##2 command_status_flags == 8'h58) else $error("no data request");
    a_lock_pulse: assert property (lock_disable |-> command_error_flags == 8'h00
        && command_status_flags == 8'h50 ##1 !lock_disable) else $error("lock pulse wrong");
    a_success_bit: assert property ($past(qry, 2) && ok |-> result_count[15] == success_store)
        else $error("success bit differs");
endmodule : ssp_cmd_monitor
`default_nettype wire

// *** tb_sanitize_status_and_password_unlock.sv ***
// Testbench for the sanitize status query and lock removal block.
// Host model issues commands; sanitize engine events are pulsed here.
`timescale 1ns/10ps
`default_nettype none
module tb_sanitize_status_and_password_unlock;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic cmd_valid, data_valid, lock_disable, success_store;
    logic [7:0] cmd_opcode, command_error_flags, command_status_flags, result_sector_number, result_cylinder_low;
    logic [15:0] cmd_feature, cmd_count, data_word, result_count;
    logic san_start = 1'b0;
    logic san_fail_hold = 1'b0;
    logic san_done_ok = 1'b0;
    logic san_done_fail = 1'b0;
    logic san_freeze = 1'b0;
    logic success_keep = 1'b0;
    logic security_enabled = 1'b1;
    logic [15:0] san_progress = 16'h0000;
    logic [255:0] user_password = {8{32'h1357_9bdf}};
    logic [255:0] master_password = {8{32'hc3a5_0f1e}};
    int fail_count = 0;
    int compares = 0;
    int cycles = 0;

    ssp_host_model host (.clk, .cmd_valid, .cmd_opcode, .cmd_feature, .cmd_count, .data_valid, .data_word);
    ssp_cmd dut (.clk, .rst_b, .cmd_valid, .cmd_opcode, .cmd_feature, .cmd_count, .data_valid, .data_word,
        .san_start, .san_fail_hold, .san_done_ok, .san_done_fail, .san_freeze, .san_progress, .success_keep,
        .security_enabled, .user_password, .master_password, .command_error_flags, .command_status_flags,
        .result_count, .result_sector_number, .result_cylinder_low, .lock_disable, .success_store);

    // 10 MHz clock; a hang is cut short well past the expected run length
    always #50 clk = ~clk;
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            fail_count++;
            end_sim();
        end
    end

    task automatic end_sim();
        $display("Comparisons %0d, mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : end_sim

    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        compares++;
        if (g !== e) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask : chk

    task automatic ev(ref logic s);
        @(negedge clk);
        s = 1'b1;
        @(negedge clk);
        s = 1'b0;
    endtask : ev

    task automatic do_reset();
        rst_b = 1'b0;
        repeat (8) @(negedge clk);
        rst_b = 1'b1;
        repeat (3) @(negedge clk);
    endtask : do_reset

    // Count and cylinder are only judged when the query completes cleanly
    task automatic qchk(input logic [15:0] cnt, input logic [7:0] e_err, input logic [15:0] e_cnt,
        input logic [15:0] e_res, input logic [15:0] feat = 16'h0000);
        host.issue(ssp_pkg::CMD_SANITIZE, feat, cnt);
        @(negedge clk);
        chk("error_flags", e_err, command_error_flags);
        chk("status", e_err[2] ? 16'h0051 : 16'h0050, command_status_flags);
        chk("sector_number", e_res[7:0], result_sector_number);
        if (!e_err[2]) begin
            chk("cylinder_low", e_res[15:8], result_cylinder_low);
            chk("count", e_cnt, result_count);
        end
    endtask : qchk

    task automatic unlock(input logic sel, input logic [255:0] pw, input logic [7:0] e_err, input logic e_ld);
        logic ld;
        ld = 1'b0;
        host.issue(ssp_pkg::CMD_UNLOCK, 16'h0000, 16'h0000);
        host.sector(sel, pw);
        for (int i = 0; i < 8; i++) begin
            @(negedge clk);
            ld = ld | lock_disable;
            if (!command_status_flags[7] && !command_status_flags[3]) break;
        end
        chk("unlock_error", e_err, command_error_flags);
        chk("unlock_status", e_err[2] ? 16'h0051 : 16'h0050, command_status_flags);
        chk("lock_disable", 16'(e_ld), 16'(ld));
    endtask : unlock

    task automatic t_idle();
        qchk(16'h0000, 8'h00, 16'h0000, 16'hffff);
        qchk(16'h0000, 8'h04, 16'h0000, 16'h0002, 16'h00ff);
    endtask : t_idle

    task automatic t_fail_hold();
        san_fail_hold = 1'b1;
        san_progress = 16'h1234;
        ev(san_start);
        qchk(16'h0000, 8'h00, 16'h4000, 16'h1234);
        ev(san_done_fail);
        qchk(16'h0000, 8'h04, 16'h0000, 16'h0001);
        qchk(16'h0001, 8'h00, 16'h0000, 16'hffff);
        qchk(16'h0000, 8'h00, 16'h0000, 16'hffff);
    endtask : t_fail_hold

    task automatic t_success_frozen();
        ev(san_start);
        ev(san_done_ok);
        qchk(16'h0000, 8'h00, 16'h8000, 16'hffff);
        chk("success_store", 16'h0001, 16'(success_store));
        ev(san_freeze);
        qchk(16'h0000, 8'h00, 16'ha000, 16'hffff);
        qchk(16'h0000, 8'h04, 16'h0000, 16'h0003, 16'h0011);
        success_keep = 1'b1;
        do_reset();
        qchk(16'h0000, 8'h00, 16'h8000, 16'hffff);
    endtask : t_success_frozen

    task automatic t_fail_nohold();
        san_fail_hold = 1'b0;
        ev(san_start);
        ev(san_done_fail);
        qchk(16'h0001, 8'h04, 16'h0000, 16'h0000);
    endtask : t_fail_nohold

    task automatic t_unlock();
        unlock(1'b0, user_password, 8'h00, 1'b1);
        unlock(1'b1, master_password, 8'h00, 1'b1);
        unlock(1'b1, user_password, 8'h04, 1'b0);
        security_enabled = 1'b0;
        unlock(1'b0, user_password, 8'h04, 1'b0);
    endtask : t_unlock

    initial begin
        do_reset();
        t_idle();
        t_fail_hold();
        t_success_frozen();
        t_fail_nohold();
        t_unlock();
        end_sim();
    end
endmodule : tb_sanitize_status_and_password_unlock

bind ssp_cmd ssp_cmd_monitor #(.PW_WORDS(PW_WORDS)) mon (.clk, .rst_b, .cmd_valid, .cmd_opcode, .cmd_feature,
    .san_progress, .command_error_flags, .command_status_flags, .result_count, .result_sector_number,
    .result_cylinder_low, .lock_disable, .success_store);
`default_nettype wire
